//--- common/fss_pkg.sv
// Shared constants for the frame security sequencer.
// Assumes both ends run on one clock and one asynchronous reset.
package fss_pkg;
  // Nonce layout: long source address, frame counter, key sequence counter.
  localparam int NONCE_W = 104;
  localparam int SRC_W = 64;
  localparam int FCTR_W = 32;
  localparam int KSEQ_W = 8;
  // Frame size limits and checksum size in octets.
  localparam logic [8:0] MAX_FRAME_LEN = 9'h07f;
  localparam logic [8:0] CRC_OCTETS = 9'h002;
  // Long-address encoding of the source address mode field.
  localparam logic [1:0] SAM_LONG = 2'h3;
  // Frame type encodings.
  localparam logic [2:0] TYPE_BEACON = 3'h0;
  localparam logic [2:0] TYPE_DATA = 3'h1;
  localparam logic [2:0] TYPE_CMD = 3'h3;
  // Field positions within mac_framing_control.
  localparam int MFC_CHECKSUM_SIZE_SELECT_BIT = 2;
  localparam int MFC_FRAME_FORMAT_SELECT_BIT = 1;
  localparam logic [7:0] MFC_RESET = 8'h00;
  // Reset values of the security material, and the header offset the device loads itself.
  localparam logic [6:0] OFFSET_RESET = 7'h00;
  localparam logic [3:0] SUITE_RESET = 4'h0;
  localparam logic [6:0] MAC_HDR_OFFSET = 7'h01;
  // Trigger bit positions; a done flag shares its trigger's position.
  localparam int TRIG_W = 5;
  localparam logic [2:0] TRG_BUF1 = 3'h0;
  localparam logic [2:0] TRG_BUF2 = 3'h1;
  localparam logic [2:0] TRG_ENC = 3'h2;
  localparam logic [2:0] TRG_SEND = 3'h3;
  localparam logic [2:0] TRG_RX_DECRYPT_TRIGGER = 3'h4;
  // Flag bit positions.
  localparam int FLAG_W = 8;
  localparam int FLG_BUF1 = 0;
  localparam int FLG_BUF2 = 1;
  localparam int FLG_ENC = 2;
  localparam int FLG_SEND = 3;
  localparam int FLG_RX_DECRYPT_TRIGGER = 4;
  localparam int FLG_RXTAG = 5;
  localparam int FLG_SIZE = 6;
  localparam int FLG_FRM = 7;
  // Security categories reported for the current frame.
  localparam logic [1:0] CAT_NONE = 2'h0;
  localparam logic [1:0] CAT_MAC = 2'h1;
  localparam logic [1:0] CAT_BEACON = 2'h2;
  // Host user commands.
  localparam logic [2:0] OP_SEND = 3'h0;
  localparam logic [2:0] OP_ENC = 3'h1;
  localparam logic [2:0] OP_RX = 3'h2;
  localparam logic [2:0] OP_RX_DUAL = 3'h3;
  localparam logic [2:0] OP_BUF1 = 3'h4;
  localparam logic [2:0] OP_BUF2 = 3'h5;
endpackage

//--- common/fss_if.sv
// Signals between the host controller end and the device end.
// Assumes both ends share the clock; the bench joins the modports.
`timescale 1ns/1ns
`default_nettype none
interface fss_if;
  import fss_pkg::*;
  // Host to device: trigger pulses, hold bit, material write, flag clear.
  logic [TRIG_W-1:0] trig_set;
  logic setup_hold;
  logic mat_wr;
  logic [NONCE_W-1:0] nonce_wr_data;
  logic [3:0] suite_wr_data;
  logic [6:0] hdr_off_wr_data;
  logic [6:0] pay_off_wr_data;
  logic [6:0] end_off_wr_data;
  logic [7:0] mac_framing_control;
  logic [FLAG_W-1:0] flag_clr;
  // Device to host: trigger bits, flags and security material.
  logic [TRIG_W-1:0] trig_busy;
  logic [FLAG_W-1:0] flags;
  logic [NONCE_W-1:0] nonce_rd;
  logic [3:0] suite_rd;
  logic [6:0] end_off_rd;
  logic [1:0] sec_category;
  modport dev (
    input trig_set, setup_hold, mat_wr, nonce_wr_data, suite_wr_data, hdr_off_wr_data,
    input pay_off_wr_data, end_off_wr_data, mac_framing_control, flag_clr,
    output trig_busy, flags, nonce_rd, suite_rd, end_off_rd, sec_category
  );
  modport host (
    output trig_set, setup_hold, mat_wr, nonce_wr_data, suite_wr_data, hdr_off_wr_data,
    output pay_off_wr_data, end_off_wr_data, mac_framing_control, flag_clr,
    input trig_busy, flags, nonce_rd, suite_rd, end_off_rd, sec_category
  );
endinterface // fss_if
`default_nettype wire

//--- rtl/fss_device.sv
// Device end of the frame security sequencer: triggers, nonce, flags.
// Assumes an external cipher engine, frame buffer fields and radio sender.
// Functional notes
// R1 - Nonce: source address, counter, key sequence
// R2 - Own long address fills nonce source
// R3 - Host writes receive nonce unless long address
// R4 - Send trigger: security then send, uninterrupted
// R5 - Host waits encrypt done before anything else
// R6 - Completion flag raised, trigger self-cleared
// R7 - Size error when zero or too large
// R8 - Encrypt tag updates length, end offset
// R9 - Receive security only on host trigger
// R10 - Dual receive: MAC first, then network
// R11 - Receive done flags raised, trigger cleared
// R12 - Classify frames by enable, version, type
// R13 - Host loads material before encrypt trigger
// R14 - Device loads suite, offsets, nonce itself
// R15 - Host sets hold after writing material; the host here sets it in the same cycle as the write
`timescale 1ns/1ns
`default_nettype none
module fss_device
  import fss_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Link to the host.
  fss_if.dev ifc,
  // Frame buffer fields of the current frame.
  input wire logic security_enabled_bit,
  input wire logic [1:0] frame_version_field,
  input wire logic [2:0] frame_type,
  input wire logic [7:0] frame_length,
  input wire logic [4:0] mic_length,
  input wire logic [6:0] mac_payload_offset,
  // Own identity and counters.
  input wire logic [SRC_W-1:0] own_long_address,
  input wire logic [FCTR_W-1:0] frame_counter_field,
  input wire logic [KSEQ_W-1:0] key_sequence_counter,
  input wire logic [3:0] default_suite,
  // Cipher engine.
  output logic crypt_start,
  output logic crypt_rx,
  input wire logic crypt_done,
  input wire logic crypt_tag_only,
  // Radio sender and buffer length write.
  output logic send_start,
  input wire logic send_done,
  output logic length_wr,
  output logic [7:0] length_wr_data
);
  // Sequencer states.
  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_CRYPT = 4'h2,
    DS_CHECK = 4'h4,
    DS_SEND = 4'h8
  } fss_dev_state_t;

  // Whole state of the device end.
  typedef struct packed {
    fss_dev_state_t st;
    logic [2:0] op;
    logic add_mic;
    logic [TRIG_W-1:0] trig;
    logic [FLAG_W-1:0] flags;
    logic [NONCE_W-1:0] nonce;
    logic [3:0] suite;
    logic [6:0] hdr_off;
    logic [6:0] pay_off;
    logic [6:0] end_off;
    logic [1:0] cat;
    logic [7:0] len;
    logic crypt_start;
    logic crypt_rx;
    logic send_start;
    logic len_wr;
  } fss_dev_s_t;

  fss_dev_s_t s_reg; // Registered state.
  fss_dev_s_t s_next; // Next state.
  logic [FLAG_W-1:0] flag_set; // Flags raised this cycle.
  logic [2:0] pick; // Trigger chosen among simultaneous sets.
  logic [8:0] total; // Frame size after tags and checksum.
  logic [8:0] crc_add; // Checksum octets added on a send.

  // Next-state logic of the sequencer.
  always_comb begin
    s_next = s_reg;
    s_next.crypt_start = 1'b0;
    s_next.send_start = 1'b0;
    s_next.len_wr = 1'b0;
    flag_set = '0;
    pick = TRG_BUF1;
    // The highest position wins when several triggers arrive together.
    for (int i = 0; i < TRIG_W; i++) begin
      if (ifc.trig_set[i]) begin
        pick = 3'(i);
      end
    end
    crc_add = '0;
    if (s_reg.op == TRG_SEND && ifc.mac_framing_control[MFC_CHECKSUM_SIZE_SELECT_BIT]) begin
      crc_add = CRC_OCTETS;
    end
    total = {1'b0, frame_length} + (s_reg.add_mic ? 9'(mic_length) : 9'h000) + crc_add;
    // R12 frame classification
    if (!security_enabled_bit || frame_version_field[1]) begin
      s_next.cat = CAT_NONE;
    end else if (frame_type == TYPE_DATA || frame_type == TYPE_CMD) begin
      s_next.cat = CAT_MAC;
    end else if (frame_type == TYPE_BEACON) begin
      s_next.cat = CAT_BEACON;
    end else begin
      s_next.cat = CAT_NONE;
    end
    case (s_reg.st)
      DS_IDLE: begin
        // Host material is taken only while no operation runs.
        if (ifc.mat_wr) begin
          s_next.nonce = ifc.nonce_wr_data;
          s_next.suite = ifc.suite_wr_data;
          s_next.hdr_off = ifc.hdr_off_wr_data;
          s_next.pay_off = ifc.pay_off_wr_data;
          s_next.end_off = ifc.end_off_wr_data;
        end
        // R9 start only on trigger
        if (|ifc.trig_set) begin
          s_next.op = pick;
          if (ifc.mac_framing_control[MFC_FRAME_FORMAT_SELECT_BIT]) begin
            // Only the standard frame format is sequenced here.
            flag_set[FLG_FRM] = 1'b1;
          end else if (pick == TRG_SEND && !security_enabled_bit) begin
            // Plain send skips the cipher but still sizes the frame.
            s_next.trig[pick] = 1'b1;
            s_next.add_mic = 1'b0;
            s_next.st = DS_CHECK;
          end else begin
            s_next.trig[pick] = 1'b1;
            s_next.add_mic = 1'b1;
            s_next.crypt_start = 1'b1;
            s_next.crypt_rx = (pick == TRG_RX_DECRYPT_TRIGGER);
            s_next.st = DS_CRYPT;
            // R14 device loads material
            if (pick == TRG_SEND && !ifc.setup_hold) begin
              s_next.suite = default_suite;
              s_next.hdr_off = MAC_HDR_OFFSET;
              s_next.pay_off = (frame_type == TYPE_CMD) ? 7'(mac_payload_offset + 7'h01) : mac_payload_offset;
              s_next.end_off = frame_length[6:0];
              // R1 nonce order
              // R2 own address as source
              s_next.nonce = {own_long_address, frame_counter_field, key_sequence_counter};
            end
          end
        end
      end
      DS_CRYPT: begin
        // Wait for the cipher engine.
        if (crypt_done) begin
          if (s_reg.crypt_rx) begin
            // R11 receive completion
            flag_set[crypt_tag_only ? FLG_RXTAG : FLG_RX_DECRYPT_TRIGGER] = 1'b1;
            s_next.trig[TRG_RX_DECRYPT_TRIGGER] = 1'b0;
            s_next.crypt_rx = 1'b0;
            s_next.st = DS_IDLE;
          end else begin
            s_next.st = DS_CHECK;
          end
        end
      end
      DS_CHECK: begin
        // R7 size error check
        if (total == 9'h000 || total > MAX_FRAME_LEN) begin
          flag_set[FLG_SIZE] = 1'b1;
          s_next.trig[s_reg.op] = 1'b0;
          s_next.st = DS_IDLE;
        end else begin
          // R8 length and end offset
          s_next.len = total[7:0];
          s_next.len_wr = 1'b1;
          if (s_reg.op == TRG_ENC && s_reg.add_mic) begin
            s_next.end_off = 7'(s_reg.end_off + 7'(mic_length));
          end
          if (s_reg.op == TRG_SEND) begin
            // R4 send follows security
            s_next.send_start = 1'b1;
            s_next.st = DS_SEND;
          end else begin
            // R6 completion and self-clear
            flag_set[s_reg.op] = 1'b1;
            s_next.trig[s_reg.op] = 1'b0;
            s_next.st = DS_IDLE;
          end
        end
      end
      DS_SEND: begin
        // R6 send completion
        if (send_done) begin
          flag_set[FLG_SEND] = 1'b1;
          s_next.trig[TRG_SEND] = 1'b0;
          s_next.st = DS_IDLE;
        end
      end
      default: begin
        s_next.st = DS_IDLE;
      end
    endcase
    // A flag raised in the cycle of its clear stays raised.
    s_next.flags = (s_reg.flags & ~ifc.flag_clr) | flag_set;
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: DS_IDLE, op: TRG_BUF1, suite: SUITE_RESET, hdr_off: OFFSET_RESET,
                 pay_off: OFFSET_RESET, end_off: OFFSET_RESET, cat: CAT_NONE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign ifc.trig_busy = s_reg.trig;
  assign ifc.flags = s_reg.flags;
  assign ifc.nonce_rd = s_reg.nonce;
  assign ifc.suite_rd = s_reg.suite;
  assign ifc.end_off_rd = s_reg.end_off;
  assign ifc.sec_category = s_reg.cat;
  assign crypt_start = s_reg.crypt_start;
  assign crypt_rx = s_reg.crypt_rx;
  assign send_start = s_reg.send_start;
  assign length_wr = s_reg.len_wr;
  assign length_wr_data = s_reg.len;
endmodule // fss_device
`default_nettype wire

//--- rtl/fss_host.sv
// Host controller end: loads material, fires triggers, awaits flags.
// Assumes a user that issues one command at a time and supplies material.
`timescale 1ns/1ns
`default_nettype none
module fss_host
  import fss_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Link to the device.
  fss_if.host ifc,
  // User command.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic own_material,
  input wire logic [1:0] source_address_mode,
  input wire logic [7:0] framing_ctrl,
  // User material, taken with a command or with mat_valid.
  input wire logic mat_valid,
  input wire logic [NONCE_W-1:0] nonce,
  input wire logic [3:0] suite,
  input wire logic [6:0] hdr_off,
  input wire logic [6:0] pay_off,
  input wire logic [6:0] end_off,
  // User status.
  output logic busy,
  output logic done,
  output logic error,
  output logic reload_req
);
  // Host states.
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_TRIG = 4'h2,
    HS_WAIT = 4'h4,
    HS_RELOAD = 4'h8
  } fss_host_state_t;

  // Whole state of the host end.
  typedef struct packed {
    fss_host_state_t st;
    logic [2:0] op;
    logic second;
    logic [TRIG_W-1:0] trig_set;
    logic hold;
    logic mat_wr;
    logic [NONCE_W-1:0] nonce;
    logic [3:0] suite;
    logic [6:0] hdr_off;
    logic [6:0] pay_off;
    logic [6:0] end_off;
    logic [7:0] framing;
    logic [FLAG_W-1:0] flag_clr;
    logic busy;
    logic done;
    logic error;
    logic reload_req;
  } fss_host_s_t;

  fss_host_s_t s_reg; // Registered state.
  fss_host_s_t s_next; // Next state.
  logic [FLAG_W-1:0] watch; // Flags that end the running command.
  logic [FLAG_W-1:0] errs; // Error flags among them.
  logic [2:0] trig_pos; // Trigger bit of the running command.
  logic is_rx; // Command is a receive one.

  // Next-state logic of the host.
  always_comb begin
    s_next = s_reg;
    s_next.trig_set = '0;
    s_next.mat_wr = 1'b0;
    s_next.flag_clr = '0;
    s_next.done = 1'b0;
    s_next.error = 1'b0;
    s_next.reload_req = 1'b0;
    s_next.framing = framing_ctrl;
    errs = '0;
    errs[FLG_SIZE] = 1'b1;
    errs[FLG_FRM] = 1'b1;
    watch = errs;
    is_rx = (s_reg.op == OP_RX || s_reg.op == OP_RX_DUAL);
    case (s_reg.op)
      OP_SEND: trig_pos = TRG_SEND;
      OP_ENC: trig_pos = TRG_ENC;
      OP_BUF1: trig_pos = TRG_BUF1;
      OP_BUF2: trig_pos = TRG_BUF2;
      default: trig_pos = TRG_RX_DECRYPT_TRIGGER;
    endcase
    // R11 receive completion flags
    if (is_rx) begin
      watch[FLG_RX_DECRYPT_TRIGGER] = 1'b1;
      watch[FLG_RXTAG] = 1'b1;
    end else begin
      watch[trig_pos] = 1'b1;
    end
    case (s_reg.st)
      HS_IDLE: begin
        if (cmd_valid) begin
          s_next.op = cmd_op;
          s_next.second = 1'b0;
          s_next.busy = 1'b1;
          // R15 hold own material
          s_next.hold = own_material;
          // R3 receive nonce write
          // R13 material before trigger
          if (own_material || ((cmd_op == OP_RX || cmd_op == OP_RX_DUAL) && source_address_mode != SAM_LONG)) begin
            s_next.mat_wr = 1'b1;
            s_next.nonce = nonce;
            s_next.suite = suite;
            s_next.hdr_off = hdr_off;
            s_next.pay_off = pay_off;
            s_next.end_off = end_off;
          end
          s_next.st = HS_TRIG;
        end
      end
      HS_TRIG: begin
        // Material was written a cycle earlier, so the trigger sees it.
        s_next.trig_set[trig_pos] = 1'b1;
        s_next.st = HS_WAIT;
      end
      HS_WAIT: begin
        // R5 wait for completion
        if (|(ifc.flags & watch)) begin
          s_next.flag_clr = ifc.flags & watch;
          if (|(ifc.flags & errs)) begin
            s_next.error = 1'b1;
            s_next.busy = 1'b0;
            s_next.st = HS_IDLE;
          end else if (s_reg.op == OP_RX_DUAL && !s_reg.second) begin
            // R10 MAC pass then network pass
            s_next.second = 1'b1;
            s_next.reload_req = 1'b1;
            s_next.st = HS_RELOAD;
          end else begin
            s_next.done = 1'b1;
            s_next.busy = 1'b0;
            s_next.st = HS_IDLE;
          end
        end
      end
      HS_RELOAD: begin
        // R10 reload network material
        if (mat_valid) begin
          s_next.mat_wr = 1'b1;
          s_next.nonce = nonce;
          s_next.suite = suite;
          s_next.hdr_off = hdr_off;
          s_next.pay_off = pay_off;
          s_next.end_off = end_off;
          s_next.st = HS_TRIG;
        end
      end
      default: begin
        s_next.st = HS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: HS_IDLE, op: OP_SEND, suite: SUITE_RESET, hdr_off: OFFSET_RESET,
                 pay_off: OFFSET_RESET, end_off: OFFSET_RESET, framing: MFC_RESET, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign ifc.trig_set = s_reg.trig_set;
  assign ifc.setup_hold = s_reg.hold;
  assign ifc.mat_wr = s_reg.mat_wr;
  assign ifc.nonce_wr_data = s_reg.nonce;
  assign ifc.suite_wr_data = s_reg.suite;
  assign ifc.hdr_off_wr_data = s_reg.hdr_off;
  assign ifc.pay_off_wr_data = s_reg.pay_off;
  assign ifc.end_off_wr_data = s_reg.end_off;
  assign ifc.mac_framing_control = s_reg.framing;
  assign ifc.flag_clr = s_reg.flag_clr;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign error = s_reg.error;
  assign reload_req = s_reg.reload_req;
endmodule // fss_host
`default_nettype wire

//--- verif/fss_checker_sva.sv
// Checker for the link between the host end and the device end.
// Assumes the bench hands it the interface signals and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module fss_checker
  import fss_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Host to device.
  input wire logic [TRIG_W-1:0] trig_set,
  input wire logic setup_hold,
  input wire logic [7:0] mac_framing_control,
  input wire logic [FLAG_W-1:0] flag_clr,
  // Device to host.
  input wire logic [TRIG_W-1:0] trig_busy,
  input wire logic [FLAG_W-1:0] flags,
  input wire logic [NONCE_W-1:0] nonce_rd,
  input wire logic [3:0] suite_rd,
  input wire logic [1:0] sec_category
);
  // All checks run on the one clock and stop during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // One operation may run at a time, so at most one trigger bit stands.
  AST_ONE_OP: assert property ($onehot0(trig_busy)) else $error("Two triggers busy at once.");
  // An idle device takes a receive trigger on the next cycle.
  AST_RX_TAKE: assert property (trig_busy == 5'h00 && $past(trig_busy) == 5'h00 && trig_set[TRG_RX_DECRYPT_TRIGGER]
    && !mac_framing_control[MFC_FRAME_FORMAT_SELECT_BIT] |=> trig_busy == 5'h10) else $error("Receive trigger not taken.");
  // Receive work never starts without the host asking.
  AST_RX_ONLY: assert property ($rose(trig_busy[TRG_RX_DECRYPT_TRIGGER]) |-> $past(trig_set[TRG_RX_DECRYPT_TRIGGER]))
    else $error("Receive work began unasked.");
  // The send trigger clears together with its done or size flag.
  AST_SEND_DONE: assert property ($fell(trig_busy[TRG_SEND]) |-> flags[FLG_SEND] || flags[FLG_SIZE])
    else $error("Send trigger cleared without a flag.");
  // The encrypt trigger clears together with its done or size flag.
  AST_ENC_DONE: assert property ($fell(trig_busy[TRG_ENC]) |-> flags[FLG_ENC] || flags[FLG_SIZE])
    else $error("Encrypt trigger cleared without a flag.");
  // The receive trigger clears together with a decrypt or tag flag.
  AST_RX_DONE: assert property ($fell(trig_busy[TRG_RX_DECRYPT_TRIGGER]) |-> flags[FLG_RX_DECRYPT_TRIGGER] || flags[FLG_RXTAG])
    else $error("Receive trigger cleared without a flag.");
  // The encrypt done flag stays up until the host clears it.
  AST_FLAG_STICKY: assert property (flags[FLG_ENC] && !flag_clr[FLG_ENC] |=> flags[FLG_ENC])
    else $error("Encrypt flag dropped uncleared.");
  // A size error ends the operation with no completion flag.
  AST_SIZE_NO_DONE: assert property ($rose(flags[FLG_SIZE]) |-> !$rose(flags[FLG_SEND])
    && !$rose(flags[FLG_ENC])) else $error("Done flag raised with size error.");
  // With the hold bit set the device keeps the host's material.
  AST_HOLD_KEEPS: assert property ($rose(trig_busy[TRG_SEND]) && setup_hold |-> $stable(nonce_rd)
    && $stable(suite_rd)) else $error("Held material was overwritten.");
  // The encrypt trigger clears itself within a bounded time.
  AST_ENC_BOUND: assert property ($rose(trig_busy[TRG_ENC]) |-> ##[1:40] !trig_busy[TRG_ENC])
    else $error("Encrypt trigger never cleared.");
  // Only the three documented categories are reported.
  AST_CAT_LEGAL: assert property (sec_category != 2'h3) else $error("Illegal category code.");
endmodule // fss_checker
`default_nettype wire

//--- verif/tb_frame_security_sequencer.sv
// Bench joining the host end and the device end across the link.
// Assumes the bench plays the cipher engine and the radio sender.
`timescale 1ns/1ns
`default_nettype none
module tb_frame_security_sequencer;
  import fss_pkg::*;
  // Clock, reset and host user side.
  logic clock, rst_n, cmd_valid, own_material, mat_valid, busy, done, error, reload_req;
  logic [2:0] cmd_op;
  logic [1:0] source_address_mode;
  logic [7:0] framing_ctrl;
  logic [NONCE_W-1:0] nonce;
  logic [3:0] suite;
  logic [6:0] hdr_off, pay_off, end_off;
  // Device user side.
  logic security_enabled_bit, crypt_start, crypt_rx, crypt_done, crypt_tag_only;
  logic send_start, send_done, length_wr, rx_seen;
  logic [1:0] frame_version_field;
  logic [2:0] frame_type;
  logic [7:0] frame_length, length_wr_data, len_seen;
  logic [4:0] mic_length;
  logic [6:0] mac_payload_offset;
  logic [SRC_W-1:0] own_long_address;
  logic [FCTR_W-1:0] frame_counter_field;
  logic [KSEQ_W-1:0] key_sequence_counter;
  logic [3:0] default_suite;
  // Bench counters; the engine counters time the modelled latencies.
  int miscompares = 0;
  int comparisons = 0;
  int reloads = 0;
  int len_cnt = 0;
  int ceng = 0;
  int seng = 0;
  // Category table: enable bit, type, version, expected category.
  logic [7:0] cat_tab [5] = '{{1'b1, TYPE_DATA, 2'h0, CAT_MAC}, {1'b1, TYPE_CMD, 2'h0, CAT_MAC},
    {1'b1, TYPE_BEACON, 2'h0, CAT_BEACON}, {1'b0, TYPE_DATA, 2'h0, CAT_NONE}, {1'b1, TYPE_DATA, 2'h2, CAT_NONE}};

  fss_if link();
  fss_device u_fss_device (.clock(clock), .rst_n(rst_n), .ifc(link.dev),
    .security_enabled_bit(security_enabled_bit), .frame_version_field(frame_version_field),
    .frame_type(frame_type), .frame_length(frame_length), .mic_length(mic_length),
    .mac_payload_offset(mac_payload_offset), .own_long_address(own_long_address),
    .frame_counter_field(frame_counter_field), .key_sequence_counter(key_sequence_counter),
    .default_suite(default_suite), .crypt_start(crypt_start), .crypt_rx(crypt_rx), .crypt_done(crypt_done),
    .crypt_tag_only(crypt_tag_only), .send_start(send_start), .send_done(send_done), .length_wr(length_wr),
    .length_wr_data(length_wr_data));
  fss_host u_fss_host (.clock(clock), .rst_n(rst_n), .ifc(link.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .own_material(own_material), .source_address_mode(source_address_mode), .framing_ctrl(framing_ctrl),
    .mat_valid(mat_valid), .nonce(nonce), .suite(suite), .hdr_off(hdr_off), .pay_off(pay_off),
    .end_off(end_off), .busy(busy), .done(done), .error(error), .reload_req(reload_req));
  fss_checker u_fss_checker (.clock(clock), .rst_n(rst_n), .trig_set(link.trig_set),
    .setup_hold(link.setup_hold), .mac_framing_control(link.mac_framing_control), .flag_clr(link.flag_clr),
    .trig_busy(link.trig_busy), .flags(link.flags), .nonce_rd(link.nonce_rd), .suite_rd(link.suite_rd),
    .sec_category(link.sec_category));

  // Free-running clock at 25 MHz.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Cipher engine answers in three cycles, the sender in two; lengths are logged.
  always @(posedge clock) begin
    #1;
    crypt_done = (ceng == 1);
    send_done = (seng == 1);
    if (ceng > 0) ceng--;
    if (seng > 0) seng--;
    if (crypt_start === 1'b1) ceng = 3;
    if (crypt_start === 1'b1) rx_seen = crypt_rx;
    if (send_start === 1'b1) seng = 2;
    if (length_wr === 1'b1) begin
      len_seen = length_wr_data;
      len_cnt++;
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one value, counting and reporting a mismatch.
  task automatic check(input logic [NONCE_W-1:0] got, input logic [NONCE_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Issues one host command, serves reload requests, checks the outcome.
  task automatic run_op(input logic [2:0] op, input logic own, input logic exp_err);
    int n;
    cmd_op = op;
    own_material = own;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    check(busy, 1'b1);
    for (n = 0; n < 300; n++) begin
      tick(1);
      if (reload_req === 1'b1) begin
        reloads++;
        mat_valid = 1'b1;
        tick(1);
        mat_valid = 1'b0;
      end
      if (done === 1'b1 || error === 1'b1) break;
    end
    check(done | error, 1'b1);
    check(error, exp_err);
    check(busy, '0);
  endtask

  // Cuts a hung run short.
  initial begin
    #(40 * 20000);
    miscompares++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {rst_n, cmd_valid, own_material, mat_valid, crypt_tag_only} = '0;
    {cmd_op, source_address_mode, suite, hdr_off, pay_off, end_off} = '0;
    framing_ctrl = 8'h04;
    nonce = 104'h0a0b0c0d0e0f10111213141516;
    {security_enabled_bit, frame_version_field, frame_type} = {1'b1, 2'h0, TYPE_DATA};
    {frame_length, mic_length, mac_payload_offset} = {8'h14, 5'h08, 7'h0a};
    own_long_address = 64'h0011223344556677;
    frame_counter_field = 32'h00000042;
    key_sequence_counter = 8'h07;
    default_suite = 4'h5;
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    tick(1);
    // Classification by enable bit, type and version.
    for (int i = 0; i < 5; i++) begin
      {security_enabled_bit, frame_type, frame_version_field} = cat_tab[i][7:2];
      tick(2);
      check(link.sec_category, cat_tab[i][1:0]);
    end
    {security_enabled_bit, frame_version_field, frame_type} = {1'b1, 2'h0, TYPE_DATA};
    // Secure send with device-loaded material.
    run_op(OP_SEND, 1'b0, 1'b0);
    check(len_seen, 8'h1e);
    check(link.nonce_rd, {own_long_address, frame_counter_field, key_sequence_counter});
    check(link.suite_rd, default_suite);
    check(link.end_off_rd, 7'h14);
    check(link.trig_busy, 5'h00);
    // Secure send with host material kept by the hold bit.
    suite = 4'h9;
    run_op(OP_SEND, 1'b1, 1'b0);
    check(link.nonce_rd, nonce);
    check(link.suite_rd, 4'h9);
    // Encrypt only: the tag extends the end offset.
    end_off = 7'h30;
    run_op(OP_ENC, 1'b1, 1'b0);
    check(link.end_off_rd, 7'h38);
    check(rx_seen, '0);
    // Size boundary: 127 octets pass, 128 and zero fail.
    frame_length = 8'h75;
    run_op(OP_SEND, 1'b0, 1'b0);
    check(len_seen, 8'h7f);
    frame_length = 8'h76;
    run_op(OP_SEND, 1'b0, 1'b1);
    check(len_cnt, 4);
    {security_enabled_bit, framing_ctrl, frame_length} = {1'b0, 8'h00, 8'h00};
    tick(2);
    run_op(OP_SEND, 1'b0, 1'b1);
    // Receive with a short source address: the host writes the nonce.
    security_enabled_bit = 1'b1;
    nonce = 104'h55aa55aa55aa55aa55aa55aa55;
    source_address_mode = 2'h2;
    crypt_tag_only = 1'b1;
    run_op(OP_RX, 1'b0, 1'b0);
    check(link.nonce_rd, 104'h55aa55aa55aa55aa55aa55aa55);
    check(rx_seen, 1'b1);
    // Receive with a long source address: the nonce is left alone.
    nonce = 104'h33cc33cc33cc33cc33cc33cc33;
    source_address_mode = SAM_LONG;
    crypt_tag_only = 1'b0;
    run_op(OP_RX, 1'b0, 1'b0);
    check(link.nonce_rd, 104'h55aa55aa55aa55aa55aa55aa55);
    // Two-layer receive: MAC pass, reload, network pass.
    run_op(OP_RX_DUAL, 1'b0, 1'b0);
    check(reloads, 1);
    // Debug buffer triggers complete and clear themselves; a bad format is refused.
    run_op(OP_BUF1, 1'b0, 1'b0);
    run_op(OP_BUF2, 1'b0, 1'b0);
    framing_ctrl = 8'h02;
    run_op(OP_ENC, 1'b0, 1'b1);
    check(link.trig_busy, 5'h00);
    complete_run();
  end
endmodule // tb_frame_security_sequencer
`default_nettype wire
